// File: core/ldf_fault_regs.sv
// Purpose: Write policy, output code, fault configuration and low and high alarm registers with loop fault
//          and link timeout handling for a current-loop DAC.
// Assumes: The serial framer hands over decoded words as one-cycle strobes on i_clock.
// Notes: The fault output is open-drain: o_fault_oe_n low means the pin is pulled low.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [R1] Unprotected writes commit when chip select rises
// [R2] Protected writes wait for a commit command
// [R3] Host commits by writing 0x00FF to 0x01
// [R4] Output code is 16-bit unsigned binary
// [R5] Reset output code depends on alarm pin
// [R6] Retry interval is (field plus one) ticks
// [R7] Retry interval ignored when masked or disabled
// [R8] Fault with retry periodically restores output code
// [R9] Retry disabled: restore after status read
// [R10] Unmasked loop fault drives low alarm current
// [R11] Masked loop fault keeps output code current
// [R12] Loop fault pulls fault pin unless disabled
// [R13] Unmasked timeout forces pin-selected alarm current
// [R14] Valid write restarts timeout counter
// [R15] No-operation write keeps link alive
// [R16] Timeout interval is (field plus one) ticks
// [R17] Timeout report mask suppresses timeout reporting
// [R18] Alarm code is level byte over zero
// [R19] Low alarm accepts only 0x00 through 0x80
// [R20] High alarm accepts only 0x80 and above
// [R21] Fifty millisecond tick from system clock
module ldf_fault_regs
  import ldf_pkg::*;
#(
  parameter int TICK_CYCLES = LDF_TICK_CYCLES
) (
  input wire logic i_clock, // System clock, 10 MHz.
  input wire logic i_resetn, // Asynchronous reset, active low.
  input wire logic i_soft_reset, // Soft reset pulse, restores defaults.
  input wire logic i_frame_done, // Pulse: valid frame ended with chip select high.
  input wire logic i_frame_write, // Frame is a write (else a read).
  input wire logic [7:0] i_frame_addr, // Frame register address.
  input wire logic [15:0] i_frame_data, // Frame write data.
  input wire logic i_alarm_polarity_pin, // Alarm polarity strap, high selects high alarm for a link timeout.
  input wire logic i_loop_fault, // Loop fault detected by the output stage.
  input wire logic i_status_read, // Pulse: software read the status register.
  output logic [15:0] o_read_data, // Registered read data for the addressed register.
  output logic [15:0] o_drive_code, // Registered code sent to the converter.
  output logic o_link_timeout, // Registered link timeout error flag.
  output logic o_fault_oe_n, // Fault pin enable, low pulls the pin low.
  output logic o_fault_out // Fault pin output value, always low.
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] write_policy, next_write_policy;
  logic [15:0] output_code, next_output_code;
  logic [15:0] fault_config, next_fault_config;
  logic [7:0] low_alarm, next_low_alarm;
  logic [7:0] high_alarm, next_high_alarm;
  logic pend_valid, next_pend_valid;
  logic [7:0] pend_addr, next_pend_addr;
  logic [15:0] pend_data, next_pend_data;
  logic [15:0] read_data, next_read_data;
  logic code_init, next_code_init;
  logic [$clog2(TICK_CYCLES)-1:0] div_cnt, next_div_cnt;
  logic tick, next_tick;
  logic [2:0] wdog_cnt, next_wdog_cnt;
  logic link_timeout, next_link_timeout;
  logic [2:0] retry_cnt, next_retry_cnt;
  ldf_state_t state, next_state;
  logic [15:0] drive_code, next_drive_code;

  logic valid_write;
  logic commit_now;
  logic [7:0] commit_addr;
  logic [15:0] commit_data;
  logic [15:0] alarm_code;
  logic tout_alarm;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // A frame write decides whether to commit now or to park the data.
  always_comb begin
    valid_write = i_frame_done & i_frame_write;
    commit_now = 1'b0;
    commit_addr = i_frame_addr;
    commit_data = i_frame_data;
    next_pend_valid = pend_valid;
    next_pend_addr = pend_addr;
    next_pend_data = pend_data;
    if (valid_write) begin
      if (!write_policy[LDF_BIT_PROTECT]) begin
        commit_now = 1'b1; // R1
      end else if (i_frame_addr == LDF_ADDR_COMMIT && i_frame_data == LDF_COMMIT_VALUE) begin
        // A commit with nothing parked is harmless; the pending slot empties either way.
        commit_now = pend_valid; // R2 R3
        commit_addr = pend_addr;
        commit_data = pend_data;
        next_pend_valid = 1'b0;
      end else if (i_frame_addr != LDF_ADDR_NOP) begin
        next_pend_valid = 1'b1; // R2
        next_pend_addr = i_frame_addr;
        next_pend_data = i_frame_data;
      end
    end
  end

  // Register updates, with range checks on the alarm levels.
  always_comb begin
    next_write_policy = write_policy;
    next_output_code = output_code;
    next_fault_config = fault_config;
    next_low_alarm = low_alarm;
    next_high_alarm = high_alarm;
    next_code_init = 1'b0;
    // Output code default is caught one cycle after reset release, since the strap is a port.
    if (code_init) begin
      next_output_code = i_alarm_polarity_pin ? LDF_RST_CODE_HIGH : LDF_RST_CODE_LOW; // R5
    end else if (commit_now) begin
      case (commit_addr)
        LDF_ADDR_WRITE_POLICY: next_write_policy = commit_data & 16'h0001;
        LDF_ADDR_OUTPUT_CODE: next_output_code = commit_data; // R4
        LDF_ADDR_FAULT_CONFIG: next_fault_config = commit_data & 16'h07FF;
        LDF_ADDR_LOW_ALARM: begin
          if (commit_data[LDF_ALARM_HI:LDF_ALARM_LO] <= LDF_ALARM_SPLIT) begin
            next_low_alarm = commit_data[LDF_ALARM_HI:LDF_ALARM_LO]; // R19
          end
        end
        LDF_ADDR_HIGH_ALARM: begin
          if (commit_data[LDF_ALARM_HI:LDF_ALARM_LO] >= LDF_ALARM_SPLIT) begin
            next_high_alarm = commit_data[LDF_ALARM_HI:LDF_ALARM_LO]; // R20
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read data is latched when a read frame completes.
  always_comb begin
    next_read_data = read_data;
    if (i_frame_done && !i_frame_write) begin
      case (i_frame_addr)
        LDF_ADDR_WRITE_POLICY: next_read_data = write_policy;
        LDF_ADDR_OUTPUT_CODE: next_read_data = output_code;
        LDF_ADDR_FAULT_CONFIG: next_read_data = fault_config;
        LDF_ADDR_LOW_ALARM: next_read_data = {low_alarm, LDF_ALARM_LOW_BYTE};
        LDF_ADDR_HIGH_ALARM: next_read_data = {high_alarm, LDF_ALARM_LOW_BYTE};
        default: next_read_data = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  // Divider gives a one-cycle tick every 50 ms.
  always_comb begin
    next_tick = 1'b0;
    next_div_cnt = div_cnt + 1'b1;
    if (div_cnt == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
      next_div_cnt = '0; // R21
      next_tick = 1'b1;
    end
  end

  // Link watchdog: any valid write (including a no-op) restarts it and clears the error.
  always_comb begin
    next_wdog_cnt = wdog_cnt;
    next_link_timeout = link_timeout;
    if (valid_write) begin
      next_wdog_cnt = 3'h0; // R14 R15
      next_link_timeout = 1'b0;
    end else if (tick && !link_timeout) begin
      if (wdog_cnt == fault_config[LDF_WDOG_HI:LDF_WDOG_LO]) begin
        next_link_timeout = 1'b1; // R16
      end else begin
        next_wdog_cnt = wdog_cnt + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output selection and fault handling
  // ----------------------------------------------------------------
  always_comb begin
    tout_alarm = link_timeout & ~fault_config[LDF_BIT_TOUT_CUR_MASK] & ~fault_config[LDF_BIT_TOUT_REP_MASK]; // R13
    // Timeout alarm level follows the strap; a loop fault without an active timeout alarm uses the low level.
    if (tout_alarm && i_alarm_polarity_pin) begin
      alarm_code = {high_alarm, LDF_ALARM_LOW_BYTE}; // R13
    end else begin
      alarm_code = {low_alarm, LDF_ALARM_LOW_BYTE}; // R18
    end
  end

  // Loop fault state machine: normal, alarm waiting for retry, or held until status read.
  always_comb begin
    next_state = state;
    next_retry_cnt = retry_cnt;
    case (state)
      LDF_ST_NORMAL: begin
        if (i_loop_fault && !fault_config[LDF_BIT_LOOP_MASK]) begin
          next_state = fault_config[LDF_BIT_RETRY_DIS] ? LDF_ST_HOLD : LDF_ST_ALARM; // R10
          next_retry_cnt = 3'h0;
        end
      end
      LDF_ST_ALARM: begin
        if (fault_config[LDF_BIT_LOOP_MASK] || fault_config[LDF_BIT_RETRY_DIS]) begin
          next_state = fault_config[LDF_BIT_LOOP_MASK] ? LDF_ST_NORMAL : LDF_ST_HOLD; // R7
        end else if (tick) begin
          if (retry_cnt == fault_config[LDF_RETRY_HI:LDF_RETRY_LO]) begin
            next_state = LDF_ST_NORMAL; // R6 R8
          end else begin
            next_retry_cnt = retry_cnt + 3'h1;
          end
        end
      end
      LDF_ST_HOLD: begin
        if (i_status_read || fault_config[LDF_BIT_LOOP_MASK]) begin
          next_state = LDF_ST_NORMAL; // R9 R11
        end
      end
      default: next_state = LDF_ST_NORMAL;
    endcase
    if (tout_alarm || state != LDF_ST_NORMAL) begin
      next_drive_code = alarm_code; // R18
    end else begin
      next_drive_code = output_code; // R4 R11
    end
  end

  // Fault pin pulled low while a reported fault is present.
  always_comb begin
    o_fault_oe_n = ~((i_loop_fault & ~fault_config[LDF_BIT_LOOP_PIN_DIS]) // R12
                     | (link_timeout & ~fault_config[LDF_BIT_TOUT_REP_MASK])); // R17
    o_fault_out = 1'b0;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Soft reset restores the pin reset defaults of the registers; read data, divider, retry count and drive code are left as they are.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      write_policy <= LDF_RST_WRITE_POLICY;
      output_code <= LDF_RST_CODE_LOW;
      fault_config <= LDF_RST_FAULT_CONFIG;
      low_alarm <= LDF_RST_LOW_ALARM;
      high_alarm <= LDF_RST_HIGH_ALARM;
      pend_valid <= 1'b0;
      pend_addr <= 8'h00;
      pend_data <= 16'h0000;
      read_data <= 16'h0000;
      code_init <= 1'b1;
      div_cnt <= '0;
      tick <= 1'b0;
      wdog_cnt <= 3'h0;
      link_timeout <= 1'b0;
      retry_cnt <= 3'h0;
      state <= LDF_ST_NORMAL;
      drive_code <= LDF_RST_CODE_LOW;
    end else if (i_soft_reset) begin
      write_policy <= LDF_RST_WRITE_POLICY;
      fault_config <= LDF_RST_FAULT_CONFIG;
      low_alarm <= LDF_RST_LOW_ALARM;
      high_alarm <= LDF_RST_HIGH_ALARM;
      pend_valid <= 1'b0;
      code_init <= 1'b1; // R5
      wdog_cnt <= 3'h0;
      link_timeout <= 1'b0;
      state <= LDF_ST_NORMAL;
    end else begin
      write_policy <= next_write_policy;
      output_code <= next_output_code;
      fault_config <= next_fault_config;
      low_alarm <= next_low_alarm;
      high_alarm <= next_high_alarm;
      pend_valid <= next_pend_valid;
      pend_addr <= next_pend_addr;
      pend_data <= next_pend_data;
      read_data <= next_read_data;
      code_init <= next_code_init;
      div_cnt <= next_div_cnt;
      tick <= next_tick;
      wdog_cnt <= next_wdog_cnt;
      link_timeout <= next_link_timeout;
      retry_cnt <= next_retry_cnt;
      state <= next_state;
      drive_code <= next_drive_code;
    end
  end

  assign o_read_data = read_data;
  assign o_drive_code = drive_code;
  assign o_link_timeout = link_timeout;

endmodule

`default_nettype wire

// File: core/ldf_pkg.sv
// Purpose: Shared constants for the loop DAC fault and configuration registers.
// Assumes: 10 MHz system clock, 8-bit register addresses, 16-bit register data.
// Notes: Register addresses match the device register map.
package ldf_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] LDF_ADDR_COMMIT = 8'h01;
  localparam logic [7:0] LDF_ADDR_NOP = 8'h02;
  localparam logic [7:0] LDF_ADDR_WRITE_POLICY = 8'h03;
  localparam logic [7:0] LDF_ADDR_OUTPUT_CODE = 8'h04;
  localparam logic [7:0] LDF_ADDR_FAULT_CONFIG = 8'h05;
  localparam logic [7:0] LDF_ADDR_LOW_ALARM = 8'h06;
  localparam logic [7:0] LDF_ADDR_HIGH_ALARM = 8'h07;

  // ----------------------------------------------------------------
  // Values and reset defaults
  // ----------------------------------------------------------------
  localparam logic [15:0] LDF_COMMIT_VALUE = 16'h00FF;
  localparam logic [15:0] LDF_RST_WRITE_POLICY = 16'h0000;
  localparam logic [15:0] LDF_RST_FAULT_CONFIG = 16'h0102;
  localparam logic [15:0] LDF_RST_CODE_LOW = 16'h2400;
  localparam logic [15:0] LDF_RST_CODE_HIGH = 16'hE800;
  localparam logic [7:0] LDF_RST_LOW_ALARM = 8'h24;
  localparam logic [7:0] LDF_RST_HIGH_ALARM = 8'hE8;
  localparam logic [7:0] LDF_ALARM_SPLIT = 8'h80;
  localparam logic [7:0] LDF_ALARM_LOW_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LDF_BIT_PROTECT = 0;
  localparam int LDF_RETRY_HI = 10;
  localparam int LDF_RETRY_LO = 8;
  localparam int LDF_BIT_RETRY_DIS = 7;
  localparam int LDF_BIT_LOOP_MASK = 6;
  localparam int LDF_BIT_LOOP_PIN_DIS = 5;
  localparam int LDF_BIT_TOUT_CUR_MASK = 4;
  localparam int LDF_WDOG_HI = 3;
  localparam int LDF_WDOG_LO = 1;
  localparam int LDF_BIT_TOUT_REP_MASK = 0;
  localparam int LDF_ALARM_HI = 15;
  localparam int LDF_ALARM_LO = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LDF_CLOCK_HZ = 10_000_000;
  localparam int LDF_TICK_MS = 50;
  localparam int LDF_TICK_CYCLES = LDF_CLOCK_HZ / 1000 * LDF_TICK_MS;

  // Retry timer states.
  typedef enum logic [2:0] {
    LDF_ST_NORMAL = 3'b001,
    LDF_ST_ALARM = 3'b010,
    LDF_ST_HOLD = 3'b100
  } ldf_state_t;

endpackage

// File: tb/ldf_fault_regs_asserts.sv
// Purpose: Port-level checks for the loop DAC fault and configuration registers.
// Assumes: Bound to ldf_fault_regs, one clock domain.
// Notes: Only relations that hold under every configuration are checked here.
`timescale 1ns/10ps
`default_nettype none
module ldf_fault_regs_asserts import ldf_pkg::*; #(
  parameter int TICK_CYCLES = LDF_TICK_CYCLES
) (
  input wire logic i_clock, // Clock.
  input wire logic i_resetn, // Reset, active low.
  input wire logic i_soft_reset, // Soft reset.
  input wire logic i_frame_done, // Frame strobe.
  input wire logic i_frame_write, // Write qualifier.
  input wire logic [7:0] i_frame_addr, // Address.
  input wire logic [15:0] i_frame_data, // Write data.
  input wire logic i_alarm_polarity_pin, // Strap.
  input wire logic i_loop_fault, // Loop fault.
  input wire logic i_status_read, // Status read.
  input wire logic [15:0] o_read_data, // Read data.
  input wire logic [15:0] o_drive_code, // Converter code.
  input wire logic o_link_timeout, // Timeout flag.
  input wire logic o_fault_oe_n, // Fault pin enable.
  input wire logic o_fault_out // Fault pin value.
);
  // Every check shares the one clock and is dropped while reset is low.
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  property p_write_clears; i_frame_done && i_frame_write |=> !o_link_timeout; endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("Timeout flag survived a write.");
  property p_tout_hold; o_link_timeout && !i_frame_done && !i_soft_reset |=> o_link_timeout; endproperty
  a_tout_hold: assert property (p_tout_hold)
    else $error("Timeout flag dropped without a write.");
  property p_tout_cause; $rose(o_link_timeout) |-> !($past(i_frame_done) && $past(i_frame_write)); endproperty
  a_tout_cause: assert property (p_tout_cause)
    else $error("Timeout raised right after a write.");
  // The strap decides the code seen two edges after reset is released.
  property p_reset_code;
    $rose(i_resetn) |-> ##2 (o_drive_code == (i_alarm_polarity_pin ? LDF_RST_CODE_HIGH : LDF_RST_CODE_LOW));
  endproperty
  a_reset_code: assert property (p_reset_code)
    else $error("Wrong code after reset.");
  property p_low_rd; i_frame_done && !i_frame_write && i_frame_addr == 8'h06 |=> o_read_data <= 16'h8000; endproperty
  a_low_rd: assert property (p_low_rd)
    else $error("Low alarm readback out of range.");
  property p_high_rd; i_frame_done && !i_frame_write && i_frame_addr == 8'h07 |=> o_read_data >= 16'h8000; endproperty
  a_high_rd: assert property (p_high_rd)
    else $error("High alarm readback out of range.");
  property p_policy_rd; i_frame_done && !i_frame_write && i_frame_addr == 8'h03 |=> o_read_data[15:1] == 15'h0; endproperty
  a_policy_rd: assert property (p_policy_rd)
    else $error("Write policy unused bits not zero.");
  property p_unmapped_rd;
    i_frame_done && !i_frame_write && (i_frame_addr < 8'h03 || i_frame_addr > 8'h07) |=> o_read_data == 16'h0;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd)
    else $error("Unmapped read not zero.");
endmodule
bind ldf_fault_regs ldf_fault_regs_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_soft_reset(i_soft_reset), .i_frame_done(i_frame_done),
  .i_frame_write(i_frame_write), .i_frame_addr(i_frame_addr), .i_frame_data(i_frame_data),
  .i_alarm_polarity_pin(i_alarm_polarity_pin), .i_loop_fault(i_loop_fault), .i_status_read(i_status_read),
  .o_read_data(o_read_data), .o_drive_code(o_drive_code), .o_link_timeout(o_link_timeout),
  .o_fault_oe_n(o_fault_oe_n), .o_fault_out(o_fault_out));
`default_nettype wire

// File: tb/ldf_host_model.sv
// Purpose: Host controller model issuing decoded register frames.
// Assumes: One frame per call, driven just after a rising edge.
// Notes: Released lines show the inverse of the last value, never stale data.
`timescale 1ns/10ps
`default_nettype none
module ldf_host_model import ldf_pkg::*; (
  input wire logic i_clock, // Bench clock.
  input wire logic [15:0] i_read_data, // Read data from the block.
  output logic o_frame_done, // Frame end strobe.
  output logic o_frame_write, // Write qualifier.
  output logic [7:0] o_frame_addr, // Frame address.
  output logic [15:0] o_frame_data // Frame data.
);
  logic [15:0] dq;
  // Idle levels at time zero.
  initial begin
    o_frame_done = 1'b0;
    o_frame_write = 1'b0;
    o_frame_addr = 8'h00;
    o_frame_data = 16'h0000;
  end
  // One frame: strobe for one cycle, then read data is taken after that edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge i_clock);
    o_frame_done <= 1'b1;
    o_frame_write <= w;
    o_frame_addr <= a;
    o_frame_data <= d;
    @(posedge i_clock);
    o_frame_done <= 1'b0;
    o_frame_write <= ~w;
    o_frame_addr <= ~a;
    o_frame_data <= ~d;
    #1 q = i_read_data;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d); xfer(1'b1, a, d, dq); endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q); xfer(1'b0, a, 16'h0000, q); endtask
  task automatic commit(); xfer(1'b1, LDF_ADDR_COMMIT, LDF_COMMIT_VALUE, dq); endtask
  task automatic nop(); xfer(1'b1, LDF_ADDR_NOP, 16'h0000, dq); endtask
endmodule
`default_nettype wire

// File: tb/tb_ldf_fault_regs.sv
// Purpose: Self-checking bench for the fault and configuration registers.
// Assumes: Tick shortened to 10 cycles, so a field of 1 gives 20 cycles.
// Notes: Fault, strap, soft reset and status read are driven by the bench.
`timescale 1ns/10ps
`default_nettype none
module tb_ldf_fault_regs import ldf_pkg::*;;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic i_soft_reset = 1'b0;
  logic i_alarm_polarity_pin = 1'b0;
  logic i_loop_fault = 1'b0;
  logic i_status_read = 1'b0;
  logic i_frame_done, i_frame_write, o_link_timeout, o_fault_oe_n, o_fault_out;
  logic [7:0] i_frame_addr;
  logic [15:0] i_frame_data, o_read_data, o_drive_code, q;
  int failures = 0;
  int checks_done = 0;
  always #50 i_clock = ~i_clock;
  ldf_fault_regs #(.TICK_CYCLES(10)) DUT (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_soft_reset(i_soft_reset), .i_frame_done(i_frame_done),
    .i_frame_write(i_frame_write), .i_frame_addr(i_frame_addr), .i_frame_data(i_frame_data),
    .i_alarm_polarity_pin(i_alarm_polarity_pin), .i_loop_fault(i_loop_fault), .i_status_read(i_status_read),
    .o_read_data(o_read_data), .o_drive_code(o_drive_code), .o_link_timeout(o_link_timeout),
    .o_fault_oe_n(o_fault_oe_n), .o_fault_out(o_fault_out));
  ldf_host_model u_host (.i_clock(i_clock), .i_read_data(o_read_data), .o_frame_done(i_frame_done),
    .o_frame_write(i_frame_write), .o_frame_addr(i_frame_addr), .o_frame_data(i_frame_data));
  // Helpers: wait edges, compare, and bounded waits on the outputs.
  task automatic after(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    u_host.rd(a, q);
    chk(q, exp);
  endtask
  task automatic wait_code(input logic [15:0] exp, input int n);
    for (int k = 0; k < n && o_drive_code !== exp; k++) after(1);
    chk(o_drive_code, exp);
  endtask
  task automatic wait_tout(input int n);
    for (int k = 0; k < n && o_link_timeout !== 1'b1; k++) after(1);
    chk(16'(o_link_timeout), 16'h0001);
  endtask
  // Returns just after the edge so the caller never reads an output in the time step that launches it.
  task automatic pins(input logic f, input logic s);
    @(posedge i_clock);
    i_loop_fault <= f;
    i_status_read <= s;
    #1;
  endtask
  task automatic t_defaults();
    chk(o_drive_code, 16'h2400);
    rd_chk(LDF_ADDR_WRITE_POLICY, 16'h0000);
    rd_chk(LDF_ADDR_OUTPUT_CODE, 16'h2400);
    rd_chk(LDF_ADDR_FAULT_CONFIG, 16'h0102);
    rd_chk(LDF_ADDR_LOW_ALARM, 16'h2400);
    rd_chk(LDF_ADDR_NOP, 16'h0000);
  endtask
  // Protected mode: a nop between the write and the commit must not discard it.
  task automatic t_writes();
    u_host.wr(LDF_ADDR_OUTPUT_CODE, 16'hA5C3);
    after(1);
    chk(o_drive_code, 16'hA5C3);
    u_host.wr(LDF_ADDR_WRITE_POLICY, 16'hFFFF);
    rd_chk(LDF_ADDR_WRITE_POLICY, 16'h0001);
    u_host.wr(LDF_ADDR_OUTPUT_CODE, 16'h1234);
    u_host.nop();
    rd_chk(LDF_ADDR_OUTPUT_CODE, 16'hA5C3);
    u_host.commit();
    after(1);
    chk(o_drive_code, 16'h1234);
    u_host.wr(LDF_ADDR_WRITE_POLICY, 16'h0000);
    u_host.commit();
    rd_chk(LDF_ADDR_WRITE_POLICY, 16'h0000);
  endtask
  task automatic t_levels();
    u_host.wr(LDF_ADDR_LOW_ALARM, 16'h8100);
    rd_chk(LDF_ADDR_LOW_ALARM, 16'h2400);
    u_host.wr(LDF_ADDR_LOW_ALARM, 16'h8000);
    rd_chk(LDF_ADDR_LOW_ALARM, 16'h8000);
    u_host.wr(LDF_ADDR_HIGH_ALARM, 16'h7F00);
    rd_chk(LDF_ADDR_HIGH_ALARM, 16'hE800);
    u_host.wr(LDF_ADDR_HIGH_ALARM, 16'h8000);
    rd_chk(LDF_ADDR_HIGH_ALARM, 16'h8000);
  endtask
  // Timeouts are masked here so only the loop fault moves the output.
  task automatic t_loop();
    u_host.wr(LDF_ADDR_FAULT_CONFIG, 16'h0113);
    pins(1'b1, 1'b0);
    wait_code(16'h8000, 4);
    chk(16'(o_fault_oe_n), 16'h0000);
    chk(16'(o_fault_out), 16'h0000);
    wait_code(16'h1234, 25);
    u_host.wr(LDF_ADDR_FAULT_CONFIG, 16'h0193);
    wait_code(16'h8000, 25);
    after(40);
    chk(o_drive_code, 16'h8000);
    pins(1'b0, 1'b1);
    pins(1'b0, 1'b0);
    wait_code(16'h1234, 4);
    u_host.wr(LDF_ADDR_FAULT_CONFIG, 16'h0153);
    pins(1'b1, 1'b0);
    after(30);
    chk(o_drive_code, 16'h1234);
    u_host.wr(LDF_ADDR_FAULT_CONFIG, 16'h0173);
    after(2);
    chk(16'(o_fault_oe_n), 16'h0001);
    pins(1'b0, 1'b0);
  endtask
  task automatic t_timeout();
    u_host.wr(LDF_ADDR_FAULT_CONFIG, 16'h0102);
    after(8);
    chk(16'(o_link_timeout), 16'h0000);
    wait_tout(20);
    chk(16'(o_fault_oe_n), 16'h0000);
    wait_code(16'h8000, 4);
    u_host.nop();
    chk(16'(o_link_timeout), 16'h0000);
    u_host.wr(LDF_ADDR_FAULT_CONFIG, 16'h0112);
    wait_tout(30);
    after(2);
    chk(o_drive_code, 16'h1234);
    u_host.wr(LDF_ADDR_FAULT_CONFIG, 16'h0113);
    after(30);
    chk(16'(o_fault_oe_n), 16'h0001);
  endtask
  // Strap high: soft reset reloads defaults and timeouts pick the high level.
  task automatic t_strap();
    @(posedge i_clock);
    i_alarm_polarity_pin <= 1'b1;
    i_soft_reset <= 1'b1;
    @(posedge i_clock);
    i_soft_reset <= 1'b0;
    after(2);
    rd_chk(LDF_ADDR_OUTPUT_CODE, 16'hE800);
    rd_chk(LDF_ADDR_FAULT_CONFIG, 16'h0102);
    u_host.wr(LDF_ADDR_OUTPUT_CODE, 16'h4000);
    wait_tout(30);
    wait_code(16'hE800, 4);
    @(posedge i_clock);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    after(3);
    chk(o_drive_code, 16'hE800);
  endtask
  task automatic close_out();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clock);
    i_resetn <= 1'b1;
    after(2);
    t_defaults();
    t_writes();
    t_levels();
    t_loop();
    t_timeout();
    t_strap();
    close_out();
  end
  // The tests need well under 2000 cycles; this cuts a hang short.
  initial begin
    #2000000;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
